/* File: bench/tb.sv */
// self-checking bench for the local register and status block
`timescale 1ns/1ns
module tb;
  import vcs_pkg::*;
  localparam logic [31:0] BASE = 32'hfeed0000;
  logic              core_clk = 1'b0;
  logic              resetn = 1'b0;
  vcs_req_t          req;
  vcs_vid_t          vid = '0;
  logic              ack;
  logic [31:0]       rdata;
  logic [7:0]        device_status;
  logic [7:0]        crop_active;
  logic [31:12]      mem_base = BASE[31:12];
  logic              hit;
  logic [31:0]       rd;
  logic [7:0]        st;
  int                miscompares = 0;
  int                check_count = 0;
  int                cycles = 0;
  always #5 core_clk = ~core_clk;
  vcs_regs vcs_regs_i (.core_clk(core_clk), .resetn(resetn),
    .mem_base(mem_base), .req(req), .vid(vid), .ack(ack),
    .rdata(rdata), .device_status(device_status),
    .crop_active(crop_active));
  vcs_host vcs_host_i (.core_clk(core_clk), .ack(ack), .rdata(rdata),
    .req(req));
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [31:0] a,
                     input logic [3:0] be_n, input logic [7:0] wd);
    vcs_host_i.access(wr, a, be_n, {24'h0, wd}, hit, rd);
  endtask : acc
  // levels settle well before the toggle, then the status lag is covered
  task automatic lines(input int n, input logic s, input logic h);
    repeat (n) begin
      @(negedge core_clk);
      vid.sync_ok = s;
      vid.hs_ok = h;
      repeat (4) @(negedge core_clk);
      vid.line_tgl = ~vid.line_tgl;
      repeat (3) @(negedge core_clk);
    end
    repeat (8) @(negedge core_clk);
  endtask : lines
  task automatic fields(input int n);
    repeat (n) begin
      repeat (4) @(negedge core_clk);
      vid.field_tgl = ~vid.field_tgl;
      repeat (3) @(negedge core_clk);
    end
    repeat (8) @(negedge core_clk);
  endtask : fields
  task automatic t_reset;
    chk("status", 8'h00, device_status);
    chk("crop", 8'h12, crop_active);
    acc(1'b0, BASE, 4'h0, 8'h0);
    chk("hit", 1'b1, hit);
    chk("rd", 32'h0, rd);
  endtask : t_reset
  task automatic t_lanes;
    acc(1'b1, BASE | 32'h00c, 4'he, 8'h55);
    acc(1'b0, BASE | 32'h00c, 4'h0, 8'h0);
    chk("crop even", 32'h55, rd);
    acc(1'b1, BASE | 32'h00c, 4'h1, 8'haa);
    acc(1'b0, BASE | 32'h00c, 4'he, 8'h0);
    chk("lane0 off wr", 32'h55, rd);
    acc(1'b0, BASE | 32'h00c, 4'h1, 8'h0);
    chk("lane0 off rd", 32'h0, rd);
    acc(1'b1, BASE | 32'h08c, 4'he, 8'h33);
    vid.field_even = 1'b1;
    vid.field_tgl = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("active even", 8'h55, crop_active);
    chk("field bit", 1'b1, device_status[5]);
    vid.field_even = 1'b0;
    vid.field_tgl = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("active odd", 8'h33, crop_active);
    chk("field bit", 1'b0, device_status[5]);
  endtask : t_lanes
  task automatic t_map;
    acc(1'b0, BASE ^ 32'h1000, 4'h0, 8'h0);
    chk("other base", 1'b0, hit);
    acc(1'b0, BASE | 32'h004, 4'h0, 8'h0);
    chk("reserved ack", 1'b1, hit);
    chk("reserved rd", 32'h0, rd);
    mem_base = BASE[31:12] ^ 20'h00001;
    acc(1'b0, BASE ^ 32'h1000, 4'h0, 8'h0);
    chk("moved base", 1'b1, hit);
    acc(1'b0, BASE, 4'h0, 8'h0);
    chk("old base", 1'b0, hit);
    mem_base = BASE[31:12];
  endtask : t_map
  task automatic t_flags;
    vid.luma_ovf = 1'b1;
    vid.chroma_ovf = 1'b1;
    vid.pll_unlock = 1'b1;
    repeat (4) @(negedge core_clk);
    vid.luma_ovf = 1'b0;
    vid.chroma_ovf = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("ovf sticky", 3'h7, device_status[2:0]);
    vid.pll_unlock = 1'b0;
    vcs_host_i.pll_poll(BASE, st);
    chk("after clear", 3'h0, device_status[2:0]);
    chk("poll end", 1'b0, st[2]);
    vid.luma_ovf = 1'b1;
    repeat (4) @(negedge core_clk);
    vid.luma_ovf = 1'b0;
    repeat (4) @(negedge core_clk);
    chk("luma set", 1'b1, device_status[1]);
    resetn = 1'b0;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    chk("reset clr", 8'h00, device_status);
  endtask : t_flags
  task automatic t_sync;
    lines(31, 1'b1, 1'b1);
    chk("present", 2'h2, device_status[7:6]);
    lines(1, 1'b1, 1'b1);
    chk("locked", 1'b1, device_status[6]);
    acc(1'b1, BASE, 4'h0, 8'h00);
    repeat (4) @(negedge core_clk);
    chk("lock wr", 2'h3, device_status[7:6]);
    lines(30, 1'b0, 1'b0);
    chk("30 lost", 2'h3, device_status[7:6]);
    lines(1, 1'b0, 1'b0);
    chk("31 lost", 2'h1, device_status[7:6]);
    lines(1, 1'b0, 1'b0);
    chk("unlock", 2'h0, device_status[7:6]);
    chk("bit 3", 1'b0, device_status[3]);
  endtask : t_sync
  task automatic t_fmt;
    vid.lines_625 = 1'b1;
    fields(31);
    chk("fmt 31", 1'b0, device_status[4]);
    fields(1);
    chk("fmt 32", 1'b1, device_status[4]);
  endtask : t_fmt
  task automatic results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (4) @(negedge core_clk);
    resetn = 1'b1;
    t_reset();
    t_lanes();
    t_map();
    t_flags();
    t_sync();
    t_fmt();
    results();
  end
endmodule : tb

/* File: bench/vcs_host.sv */
// pci host model issuing single memory target accesses
`timescale 1ns/1ns
module vcs_host (
  input  wire logic              core_clk,
  input  wire logic              ack,
  input  wire logic [31:0]       rdata,
  output vcs_pkg::vcs_req_t      req
);
  import vcs_pkg::*;
  initial req = '0;
  // one access per call; the answer stands from the taking edge to the next
  task automatic access(input logic wr, input logic [31:0] a,
                        input logic [3:0] be_n, input logic [31:0] wd,
                        output logic hit, output logic [31:0] rd);
    @(negedge core_clk);
    req = '{1'b1, wr, a[31:2], be_n, wd};
    @(negedge core_clk);
    hit = ack;
    rd = rdata;
    // released lines flip so stale values never look valid
    req = '{1'b0, ~wr, ~a[31:2], ~be_n, ~wd};
  endtask : access
  // read and clear until the unlock flag stays low, bounded tries
  task automatic pll_poll(input logic [31:0] a, output logic [7:0] st);
    logic        h;
    logic [31:0] d;
    for (int i = 0; i < 8; i++) begin
      access(1'b0, a, 4'he, 32'h0, h, d);
      st = d[7:0];
      if (!d[2]) break;
      access(1'b1, a, 4'he, 32'h0, h, d);
    end
  endtask : pll_poll
endmodule : vcs_host

/* File: src/vcs_cfg.svh */
// offsets, field positions, reset values and counts of the status block
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH

`define VCS_WIN_BITS      12
`define VCS_OFF_STATUS    12'h000
`define VCS_OFF_CROP_EVEN 12'h00c
`define VCS_OFF_CROP_ODD  12'h08c

`define VCS_STATUS_RST    8'h00
`define VCS_CROP_RST      8'h12

`define VCS_BIT_PRESENT   7
`define VCS_BIT_HLOCK     6
`define VCS_BIT_FIELD     5
`define VCS_BIT_LINE_FORMAT_FLAG      4
`define VCS_BIT_RSVD      3
`define VCS_BIT_PLL       2
`define VCS_BIT_LUMA      1
`define VCS_BIT_CHROMA    0

`define VCS_LOST_LINES    5'h1f
`define VCS_LOCK_LINES    6'h20
`define VCS_FMT_FIELDS    6'h20

`endif

/* File: src/vcs_pkg.sv */
// types shared by the status and local register block
package vcs_pkg;

  // one decoded memory target access on the pci clock
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:2] addr;
    logic [3:0]  be_n;
    logic [31:0] wdata;
  } vcs_req_t;

  // status lines from the video decoder side, not on core_clk
  typedef struct packed {
    logic line_tgl;
    logic field_tgl;
    logic sync_ok;
    logic hs_ok;
    logic field_even;
    logic lines_625;
    logic pll_unlock;
    logic luma_ovf;
    logic chroma_ovf;
  } vcs_vid_t;

  typedef struct packed {
    vcs_vid_t    meta;
    vcs_vid_t    sync;
    vcs_vid_t    prev;
    logic [4:0]  miss_cnt;
    logic [5:0]  lock_cnt;
    logic [5:0]  fmt_cnt;
    logic        present;
    logic        hlock;
    logic        line_format_flag;
    logic        luma;
    logic        chroma;
    logic [7:0]  crop_even;
    logic [7:0]  crop_odd;
    logic [7:0]  crop_active;
    logic [7:0]  status;
    logic        ack;
    logic [31:0] rdata;
  } vcs_state_t;

endpackage : vcs_pkg

/* File: src/vcs_regs.sv */
// local register access path and device status register
//
// How it works
// [R1] one 4 kB window, one dword per register
// [R2] accesses taken at any time, no precondition
// [R3] register chosen by AD[11:2] alone, byte enables only gate lane 0
// [R4] offsets are 12 bits above the base
// [R5] any byte enable mix is accepted
// [R6] register data moves on lane 0 only
// [R7] upper lanes read back as zero
// [R8] byte registers sit four bytes apart
// [R9] unused addresses reserved, read zero here
// [R10] field registers keep even and odd copies
// [R11] status at 0x000, eight bits, resets 0x00
// [R12] overflow flags sticky, others show live status
// [R13] 31 sync-less lines clear video present
// [R14] 32 lines in window set horizontal lock
// [R15] 32 lines off window clear horizontal lock
// [R16] writes never touch horizontal lock
// [R17] bit 5 shows current field, 1 even
// [R18] line format flips after 32 fields disagreeing with it
// [R19] bit 2 high while pll out of lock
// [R20] software polls and clears pll flag first; here a status write leaves bit 2 alone, it follows pll_unlock
// [R21] luma overflow sticky, write or reset clears
// [R22] chroma overflow sticky, write or reset clears
// [R23] even and odd copies 0x80 bytes apart
// [R24] sync seen sets present, bit 3 zero
`timescale 1ns/1ns
`include "vcs_cfg.svh"

module vcs_regs (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [31:12]        mem_base,
  input  wire vcs_pkg::vcs_req_t   req,
  input  wire vcs_pkg::vcs_vid_t   vid,
  output logic                     ack,
  output logic [31:0]              rdata,
  output logic [7:0]               device_status,
  output logic [7:0]               crop_active
);
  import vcs_pkg::*;

  vcs_state_t st_r;
  vcs_state_t st_nxt;

  logic                      hit;
  logic                      wr_lane0;
  logic [`VCS_WIN_BITS-1:0]  off;
  logic                      line_edge;
  logic                      field_edge;
  logic                      wr_status;

  // window match on the relocatable base, offset from AD[11:2]
  assign hit        = req.valid && (req.addr[31:12] == mem_base); // [R1] [R4]
  assign off        = {req.addr[11:2], 2'b00};                    // [R3] [R8]
  assign wr_lane0   = hit && req.write && !req.be_n[0];           // [R5] [R6]
  assign wr_status  = wr_lane0 && (off == `VCS_OFF_STATUS);
  assign line_edge  = st_r.sync.line_tgl ^ st_r.prev.line_tgl;
  assign field_edge = st_r.sync.field_tgl ^ st_r.prev.field_tgl;

  always_comb begin
    logic [4:0] miss_inc;
    logic [5:0] lock_inc;
    logic [5:0] fmt_inc;
    logic [7:0] rd_byte;
    st_nxt   = st_r;
    miss_inc = 5'h00;
    lock_inc = 6'h00;
    fmt_inc  = 6'h00;
    rd_byte  = 8'h00;

    // decoder status crosses in through two flops
    st_nxt.meta = vid;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = st_r.sync;

    // video presence
    if (line_edge) begin
      if (st_r.sync.sync_ok) begin
        st_nxt.miss_cnt = 5'h00;
        st_nxt.present  = 1'b1;                                   // [R24]
      end else begin
        miss_inc = (st_r.miss_cnt == `VCS_LOST_LINES) ?
                   st_r.miss_cnt : st_r.miss_cnt + 5'h01;
        st_nxt.miss_cnt = miss_inc;
        if (miss_inc == `VCS_LOST_LINES) begin
          st_nxt.present = 1'b0;                                  // [R13]
        end
      end
    end

    // horizontal lock: a run of lines disagreeing with the flag flips it;
    // any agreeing line restarts the run, so the run must be unbroken
    if (line_edge) begin
      if (st_r.sync.hs_ok == st_r.hlock) begin
        st_nxt.lock_cnt = 6'h00;
      end else begin
        lock_inc = st_r.lock_cnt + 6'h01;
        if (lock_inc == `VCS_LOCK_LINES) begin
          st_nxt.hlock    = ~st_r.hlock;                          // [R14] [R15]
          st_nxt.lock_cnt = 6'h00;
        end else begin
          st_nxt.lock_cnt = lock_inc;
        end
      end
    end

    // line format, same scheme counted per field
    if (field_edge) begin
      if (st_r.sync.lines_625 == st_r.line_format_flag) begin
        st_nxt.fmt_cnt = 6'h00;
      end else begin
        fmt_inc = st_r.fmt_cnt + 6'h01;
        if (fmt_inc == `VCS_FMT_FIELDS) begin
          st_nxt.line_format_flag    = ~st_r.line_format_flag;                            // [R18]
          st_nxt.fmt_cnt = 6'h00;
        end else begin
          st_nxt.fmt_cnt = fmt_inc;
        end
      end
    end

    // sticky overflows: any lane 0 write to the status register clears,
    // an overflow in the same cycle wins over the clear
    if (wr_status) begin
      st_nxt.luma   = 1'b0;                                       // [R21]
      st_nxt.chroma = 1'b0;                                       // [R22]
    end
    if (st_r.sync.luma_ovf) begin
      st_nxt.luma = 1'b1;                                         // [R12] [R21]
    end
    if (st_r.sync.chroma_ovf) begin
      st_nxt.chroma = 1'b1;                                       // [R12] [R22]
    end

    // status image; hlock, present, field, format, pll are not writable
    st_nxt.status                  = `VCS_STATUS_RST;             // [R11]
    st_nxt.status[`VCS_BIT_PRESENT] = st_r.present;
    st_nxt.status[`VCS_BIT_HLOCK]  = st_r.hlock;                  // [R16]
    st_nxt.status[`VCS_BIT_FIELD]  = st_r.sync.field_even;        // [R17]
    st_nxt.status[`VCS_BIT_LINE_FORMAT_FLAG]   = st_r.line_format_flag;
    st_nxt.status[`VCS_BIT_RSVD]   = 1'b0;                        // [R24]
    st_nxt.status[`VCS_BIT_PLL]    = st_r.sync.pll_unlock;        // [R19]
    st_nxt.status[`VCS_BIT_LUMA]   = st_r.luma;
    st_nxt.status[`VCS_BIT_CHROMA] = st_r.chroma;

    // field-dependent copies, 0x80 apart, switched by the field bit
    if (wr_lane0 && off == `VCS_OFF_CROP_EVEN) begin
      st_nxt.crop_even = req.wdata[7:0];                          // [R23]
    end
    if (wr_lane0 && off == `VCS_OFF_CROP_ODD) begin
      st_nxt.crop_odd = req.wdata[7:0];                           // [R23]
    end
    st_nxt.crop_active = st_r.sync.field_even ?
                         st_r.crop_even : st_r.crop_odd;          // [R10]

    // answer every hit one cycle later, busy or not
    st_nxt.ack = hit;                                             // [R2]
    case (off)
      `VCS_OFF_STATUS:    rd_byte = st_r.status;
      `VCS_OFF_CROP_EVEN: rd_byte = st_r.crop_even;
      `VCS_OFF_CROP_ODD:  rd_byte = st_r.crop_odd;
      default:            rd_byte = 8'h00;                        // [R9]
    endcase
    // a disabled lane 0 reads zero too, keeping the bus quiet
    st_nxt.rdata = 32'h0000_0000;                                 // [R7]
    if (hit && !req.write && !req.be_n[0]) begin
      st_nxt.rdata = {24'h00_0000, rd_byte};                      // [R6]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r           <= '0;
      st_r.status    <= `VCS_STATUS_RST;                          // [R11]
      st_r.crop_even <= `VCS_CROP_RST;
      st_r.crop_odd  <= `VCS_CROP_RST;
      st_r.crop_active <= `VCS_CROP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ack           = st_r.ack;
  assign rdata         = st_r.rdata;
  assign device_status = st_r.status;
  assign crop_active   = st_r.crop_active;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_ACK_NEXT: assert property ( // [R2]
    hit |=> ack ##1 (!ack || $past(hit)))
    else $error("hit not answered next cycle");

  AST_UPPER_ZERO: assert property ( // [R7]
    ack |-> rdata[31:8] == 24'h00_0000)
    else $error("upper lanes not zero");

  AST_VIDEO_PRESENT_FLAG_DROP: assert property ( // [R13]
    line_edge && !st_r.sync.sync_ok && st_r.miss_cnt == 5'h1e
    |=> !st_r.present ##1 !device_status[7])
    else $error("present not cleared after 31 lines");

  AST_VIDEO_PRESENT_FLAG_SET: assert property ( // [R24]
    line_edge && st_r.sync.sync_ok |=> st_r.present ##1 device_status[7])
    else $error("present not set on sync");

  AST_LOCK_RUN: assert property ( // [R14]
    $rose(st_r.hlock) |-> $past(st_r.lock_cnt) == 6'h1f && $past(line_edge))
    else $error("lock set without 32 line run");

  AST_UNLOCK_RUN: assert property ( // [R15]
    $fell(st_r.hlock) |-> $past(st_r.lock_cnt) == 6'h1f
                          && !$past(st_r.sync.hs_ok))
    else $error("lock cleared without 32 line run");

  AST_HLOCK_NOWR: assert property ( // [R16]
    wr_status && !line_edge |=> $stable(st_r.hlock))
    else $error("write changed horizontal lock");

  AST_LUMA_SET: assert property ( // [R21]
    st_r.sync.luma_ovf |=> st_r.luma ##1 device_status[1])
    else $error("luma overflow lost");

  AST_CHROMA_HOLD: assert property ( // [R22]
    st_r.chroma && !wr_status |=> st_r.chroma)
    else $error("chroma overflow not sticky");

  AST_FIELD_SEL: assert property ( // [R10]
    ##1 crop_active == ($past(st_r.sync.field_even) ?
                        $past(st_r.crop_even) : $past(st_r.crop_odd)))
    else $error("wrong field copy active");

  AST_LINE_FORMAT_FLAG_RUN: assert property ( // [R18]
    $changed(st_r.line_format_flag) |-> $past(st_r.fmt_cnt) == 6'h1f)
    else $error("format flipped early");

  AST_RSVD_ZERO: assert property ( // [R24]
    device_status[3] == 1'b0)
    else $error("reserved status bit set");

  AST_ACK_ONLY_HIT: assert property ( // [R1]
    ack |-> $past(hit))
    else $error("answer without a hit");

  AST_RD_IDLE_ZERO: assert property ( // [R7]
    !ack |-> rdata == 32'h0000_0000)
    else $error("read data outside an answer");

  AST_RD_LANE_OFF: assert property ( // [R5]
    hit && !req.write && req.be_n[0] |=> rdata == 32'h0000_0000)
    else $error("disabled lane 0 read not zero");

  AST_WR_LANE_OFF: assert property ( // [R6]
    hit && req.write && req.be_n[0]
    |=> $stable(st_r.crop_even) && $stable(st_r.crop_odd))
    else $error("write without lane 0 stored");

  AST_EVEN_WR: assert property ( // [R23]
    wr_lane0 && off == `VCS_OFF_CROP_EVEN
    |=> st_r.crop_even == $past(req.wdata[7:0]))
    else $error("even copy not written");

  AST_ODD_WR: assert property ( // [R23]
    wr_lane0 && off == `VCS_OFF_CROP_ODD
    |=> st_r.crop_odd == $past(req.wdata[7:0]))
    else $error("odd copy not written");

  AST_STATUS_RD: assert property ( // [R11]
    hit && !req.write && !req.be_n[0] && off == `VCS_OFF_STATUS
    |=> rdata == {24'h00_0000, $past(device_status)})
    else $error("status read mismatch");

  AST_RSVD_RD: assert property ( // [R9]
    hit && !req.write && off != `VCS_OFF_STATUS
    && off != `VCS_OFF_CROP_EVEN && off != `VCS_OFF_CROP_ODD
    |=> rdata == 32'h0000_0000)
    else $error("reserved address read not zero");

  AST_FIELD_BIT: assert property ( // [R17]
    ##1 device_status[5] == $past(st_r.sync.field_even))
    else $error("field bit does not follow the decoder");

  AST_PLL_BIT: assert property ( // [R19]
    ##1 device_status[2] == $past(st_r.sync.pll_unlock))
    else $error("pll bit does not follow the lock state");

  AST_LINE_FORMAT_FLAG_BIT: assert property ( // [R18]
    ##1 device_status[4] == $past(st_r.line_format_flag))
    else $error("format bit does not follow the flag");

  AST_HLOCK_BIT: assert property ( // [R16]
    ##1 device_status[6] == $past(st_r.hlock))
    else $error("lock bit does not follow the detector");

  AST_VIDEO_PRESENT_FLAG_HOLD: assert property ( // [R13]
    line_edge && !st_r.sync.sync_ok && st_r.miss_cnt < 5'h1e
    |=> st_r.present == $past(st_r.present))
    else $error("present cleared before 31 lines");

  AST_LOCK_HOLD: assert property ( // [R14]
    line_edge && st_r.sync.hs_ok == st_r.hlock |=> $stable(st_r.hlock))
    else $error("lock flipped on an agreeing line");

  AST_LUMA_HOLD: assert property ( // [R21]
    st_r.luma && !wr_status |=> st_r.luma)
    else $error("luma overflow not sticky");

  AST_CHROMA_SET: assert property ( // [R22]
    st_r.sync.chroma_ovf |=> st_r.chroma)
    else $error("chroma overflow lost");

  AST_OVF_CLEAR: assert property ( // [R12]
    wr_status && !st_r.sync.luma_ovf && !st_r.sync.chroma_ovf
    |=> !st_r.luma && !st_r.chroma)
    else $error("overflow flags not cleared by write");

endmodule : vcs_regs
